// >>> rtl/jdta_pkg.sv
package jdta_pkg;

    // tap controller states, one-hot
    typedef enum logic [15:0] {
        ST_RESET = 16'h0001, ST_IDLE  = 16'h0002, ST_SELDR = 16'h0004, ST_CAPDR = 16'h0008,
        ST_SHDR  = 16'h0010, ST_EX1DR = 16'h0020, ST_PSDR  = 16'h0040, ST_EX2DR = 16'h0080,
        ST_UPDR  = 16'h0100, ST_SELIR = 16'h0200, ST_CAPIR = 16'h0400, ST_SHIR  = 16'h0800,
        ST_EX1IR = 16'h1000, ST_PSIR  = 16'h2000, ST_EX2IR = 16'h4000, ST_UPIR  = 16'h8000
    } jdta_state_t;

    // instruction codes, 4-bit instruction register
    localparam logic [3:0] IR_EXTEST   = 4'h0;
    localparam logic [3:0] IR_SAMPLE   = 4'h1;
    localparam logic [3:0] IR_DEVICE_IDENTIFICATION   = 4'h2;
    localparam logic [3:0] IR_USERCODE = 4'h3;
    localparam logic [3:0] IR_ACCESS   = 4'h4;
    localparam logic [3:0] IR_BYPASS   = 4'hf;
    localparam logic [3:0] IR_CAPTURE  = 4'h1;

    // data register lengths
    localparam logic [5:0] LEN_BYPASS = 6'h01;
    localparam logic [5:0] LEN_WORD   = 6'h20;
    localparam logic [5:0] LEN_BSR    = 6'h10;
    localparam int         IO_W       = 8;

    // identification word fields; values are arbitrary
    localparam logic [3:0]  ID_VERSION  = 4'h1;
    localparam logic [15:0] ID_PART     = 16'h00a5;
    localparam logic [10:0] ID_MAKER    = 11'h055;
    localparam logic [15:0] DIE_REVISION = 16'h0001;

    // security word bit positions
    localparam int SEC_TAP_OFF = 0;
    localparam int SEC_OTP_OFF = 13;
    localparam int SEC_DBG_OFF = 14;
    localparam int UID_LSB     = 22;

    // access word layout: write, target, address, data
    localparam int ACC_WR_BIT  = 31;
    localparam int ACC_TGT_LSB = 29;
    localparam int ACC_ADR_LSB = 16;
    localparam logic [1:0] TGT_TILE   = 2'h0;
    localparam logic [1:0] TGT_SWITCH = 2'h1;
    localparam logic [1:0] TGT_OTP    = 2'h2;

endpackage

// >>> rtl/jdta_tap.sv
`timescale 1ns/100ps
module jdta_tap #(
    parameter logic [3:0] IR_RESET = 4'hf
) (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        tap_rst,
    input  wire logic        tck_rise,
    input  wire logic        tck_fall,
    input  wire logic        tms,
    input  wire logic        tdi,
    input  wire logic [5:0]  dr_len,
    input  wire logic [31:0] dr_cap,
    output logic [3:0]       ir,
    output logic [31:0]      dr,
    output logic             upd_dr,
    output logic             in_reset,
    output logic             shifting,
    output logic             tdo
);
    jdta_pkg::jdta_state_t state_q, state_d;
    logic [3:0]  ir_q, ir_sr_q;
    logic [31:0] dr_q, dr_sh;
    logic        tdo_q;

    // next state of the standard tap walk
    always_comb begin
        unique case (state_q)
            jdta_pkg::ST_RESET: state_d = tms ? jdta_pkg::ST_RESET : jdta_pkg::ST_IDLE;
            jdta_pkg::ST_IDLE:  state_d = tms ? jdta_pkg::ST_SELDR : jdta_pkg::ST_IDLE;
            jdta_pkg::ST_SELDR: state_d = tms ? jdta_pkg::ST_SELIR : jdta_pkg::ST_CAPDR;
            jdta_pkg::ST_CAPDR: state_d = tms ? jdta_pkg::ST_EX1DR : jdta_pkg::ST_SHDR;
            jdta_pkg::ST_SHDR:  state_d = tms ? jdta_pkg::ST_EX1DR : jdta_pkg::ST_SHDR;
            jdta_pkg::ST_EX1DR: state_d = tms ? jdta_pkg::ST_UPDR  : jdta_pkg::ST_PSDR;
            jdta_pkg::ST_PSDR:  state_d = tms ? jdta_pkg::ST_EX2DR : jdta_pkg::ST_PSDR;
            jdta_pkg::ST_EX2DR: state_d = tms ? jdta_pkg::ST_UPDR  : jdta_pkg::ST_SHDR;
            jdta_pkg::ST_UPDR:  state_d = tms ? jdta_pkg::ST_SELDR : jdta_pkg::ST_IDLE;
            jdta_pkg::ST_SELIR: state_d = tms ? jdta_pkg::ST_RESET : jdta_pkg::ST_CAPIR;
            jdta_pkg::ST_CAPIR: state_d = tms ? jdta_pkg::ST_EX1IR : jdta_pkg::ST_SHIR;
            jdta_pkg::ST_SHIR:  state_d = tms ? jdta_pkg::ST_EX1IR : jdta_pkg::ST_SHIR;
            jdta_pkg::ST_EX1IR: state_d = tms ? jdta_pkg::ST_UPIR  : jdta_pkg::ST_PSIR;
            jdta_pkg::ST_PSIR:  state_d = tms ? jdta_pkg::ST_EX2IR : jdta_pkg::ST_PSIR;
            jdta_pkg::ST_EX2IR: state_d = tms ? jdta_pkg::ST_UPIR  : jdta_pkg::ST_SHIR;
            jdta_pkg::ST_UPIR:  state_d = tms ? jdta_pkg::ST_SELDR : jdta_pkg::ST_IDLE;
            default:            state_d = jdta_pkg::ST_RESET;
        endcase
    end

    // data shift with the serial input entering at bit len-1
    genvar i;
    generate
        for (i = 0; i < 32; i++) begin : g_sh
            if (i == 31) begin : g_top
                assign dr_sh[i] = (dr_len == 6'h20) ? tdi : 1'b0;
            end else begin : g_mid
                assign dr_sh[i] = (6'(i + 1) == dr_len) ? tdi :
                                  (6'(i + 1) < dr_len) ? dr_q[i + 1] : 1'b0;
            end
        end
    endgenerate

    // state walk on sampled tck rise, test reset overrides
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= jdta_pkg::ST_RESET;
        end else if (tap_rst) begin
            state_q <= jdta_pkg::ST_RESET;
        end else if (tck_rise) begin
            state_q <= state_d;
        end
    end

    // capture and shift on tck rise, update and tdo on tck fall
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ir_q    <= IR_RESET;
            ir_sr_q <= jdta_pkg::IR_CAPTURE;
            dr_q    <= 32'h0000_0000;
            tdo_q   <= 1'b0;
        end else if (state_q == jdta_pkg::ST_RESET) begin
            ir_q <= IR_RESET;
        end else begin
            if (tck_rise && state_q == jdta_pkg::ST_CAPIR) ir_sr_q <= jdta_pkg::IR_CAPTURE;
            if (tck_rise && state_q == jdta_pkg::ST_SHIR)  ir_sr_q <= {tdi, ir_sr_q[3:1]};
            if (tck_rise && state_q == jdta_pkg::ST_CAPDR) dr_q <= dr_cap;
            if (tck_rise && state_q == jdta_pkg::ST_SHDR)  dr_q <= dr_sh;
            if (tck_fall && state_q == jdta_pkg::ST_UPIR)  ir_q <= ir_sr_q;
            if (tck_fall) tdo_q <= (state_q == jdta_pkg::ST_SHIR) ? ir_sr_q[0] : dr_q[0];
        end
    end

    assign ir       = ir_q;
    assign dr       = dr_q;
    assign tdo      = tdo_q;
    assign upd_dr   = tck_fall && state_q == jdta_pkg::ST_UPDR;
    assign in_reset = state_q == jdta_pkg::ST_RESET;
    assign shifting = state_q == jdta_pkg::ST_SHDR || state_q == jdta_pkg::ST_SHIR;

endmodule

// >>> rtl/jdta_top.sv
`timescale 1ns/100ps
// Functional notes
// - after reset the chain holds two taps: boundary-scan then chip tap
// - boundary-scan tap follows standard test access port and scans the io pins
// - chip tap reaches tile, switch and otp for code load and debug
// - test reset low holds both taps in test-logic-reset and the serial output disabled
// - debug pin as output floats until breakpoint, then drives low
// - debug pin as input: external low forces tile into debug mode
// - software enables select how the debug pin behaves
// - identification word: version, part, maker, bit 0 one, lsb first
// - user word: user identifier from security bits 31..22, unused, die revision
// - unprogrammed otp gives an all-zero user identifier
// - global reset is active low and asserts asynchronously
// - after reset release boot starts only once pll lock is seen
// - security bit 0 shuts test access to tile state and memory
// - security bit 13 blocks test reads and writes to otp
// - security bit 14 disables the debug pin entirely
module jdta_top (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        tck,
    input  wire logic        tms,
    input  wire logic        tdi,
    input  wire logic        trst_n,
    output logic             tdo,
    output logic             tdo_oe,
    input  wire logic [31:0] sec_bits,
    input  wire logic        pll_locked,
    input  wire logic [1:0]  boot_mode,
    output logic             boot_start,
    output logic [1:0]       boot_mode_sel,
    input  wire logic [7:0]  io_pin_in,
    input  wire logic [7:0]  core_out,
    output logic [7:0]       io_pin_out,
    input  wire logic        dbg_out_en,
    input  wire logic        dbg_in_en,
    input  wire logic        at_breakpoint,
    input  wire logic        dbg_pin_in,
    output logic             dbg_pin_out,
    output logic             dbg_pin_oe,
    output logic             force_debug,
    output logic             acc_req,
    output logic             acc_wr,
    output logic [1:0]       acc_target,
    output logic [12:0]      acc_addr,
    output logic [15:0]      acc_wdata,
    input  wire logic [15:0] acc_rdata
);
    logic [1:0]  tck_s_q, tms_s_q, tdi_s_q, trst_s_q, dbg_s_q, lock_s_q;
    logic [7:0]  io_s1_q, io_s2_q;
    logic        tck_d_q;
    logic        tdo_q, tdo_oe_q, boot_q, dbg_oe_q, force_q;
    logic [1:0]  boot_sel_q;
    logic [7:0]  pin_out_q, bsr_upd_q;
    logic        acc_req_q, acc_wr_q, acc_blk_q, rd_pend_q;
    logic [1:0]  acc_tgt_q;
    logic [12:0] acc_adr_q;
    logic [15:0] acc_wd_q, rdata_q;

    // synchronisers: tck, tms, tdi, test reset, debug pin, pll lock, io pins
    // two-stage sync
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tck_s_q  <= 2'h0;
            tms_s_q  <= 2'h3;
            tdi_s_q  <= 2'h0;
            trst_s_q <= 2'h0;
            dbg_s_q  <= 2'h3;
            lock_s_q <= 2'h0;
            io_s1_q  <= 8'h00;
            io_s2_q  <= 8'h00;
            tck_d_q  <= 1'b0;
        end else begin
            tck_s_q  <= {tck_s_q[0], tck};
            tms_s_q  <= {tms_s_q[0], tms};
            tdi_s_q  <= {tdi_s_q[0], tdi};
            trst_s_q <= {trst_s_q[0], trst_n};
            dbg_s_q  <= {dbg_s_q[0], dbg_pin_in};
            lock_s_q <= {lock_s_q[0], pll_locked};
            io_s1_q  <= io_pin_in;
            io_s2_q  <= io_s1_q;
            tck_d_q  <= tck_s_q[1];
        end
    end

    // edge detect and test reset on second-stage values, security bits decoded straight from sec_bits
    wire        tck_rise = tck_s_q[1] & ~tck_d_q;
    wire        tck_fall = ~tck_s_q[1] & tck_d_q;
    wire        tap_rst  = ~trst_s_q[1];
    wire        tap_off  = sec_bits[jdta_pkg::SEC_TAP_OFF];
    wire        otp_off  = sec_bits[jdta_pkg::SEC_OTP_OFF];
    wire        dbg_off  = sec_bits[jdta_pkg::SEC_DBG_OFF];
    wire [3:0]  bs_ir, cp_ir;
    wire [31:0] bs_dr, cp_dr;
    wire        bs_upd, cp_upd, bs_tlr, cp_tlr, cp_shift, bs_tdo, cp_tdo;

    // identification word, bit 0 fixed at one
    wire [31:0] id_word  = {jdta_pkg::ID_VERSION, jdta_pkg::ID_PART, jdta_pkg::ID_MAKER, 1'b1};
    // user identifier, unused field, die revision
    // zero uid when otp is blank
    wire [31:0] usr_word = {sec_bits[31:jdta_pkg::UID_LSB], 6'h00, jdta_pkg::DIE_REVISION};
    // boundary register: pin capture low, output cells high
    wire [31:0] bsr_cap  = {16'h0000, core_out, io_s2_q};
    wire        bs_bsr   = bs_ir == jdta_pkg::IR_EXTEST || bs_ir == jdta_pkg::IR_SAMPLE;
    wire        bs_word  = bs_ir == jdta_pkg::IR_DEVICE_IDENTIFICATION || bs_ir == jdta_pkg::IR_USERCODE;
    wire [5:0]  bs_len   = bs_bsr ? jdta_pkg::LEN_BSR : bs_word ? jdta_pkg::LEN_WORD : jdta_pkg::LEN_BYPASS;
    wire [31:0] bs_cap   = bs_bsr ? bsr_cap :
                           bs_ir == jdta_pkg::IR_DEVICE_IDENTIFICATION   ? id_word :
                           bs_ir == jdta_pkg::IR_USERCODE ? usr_word : 32'h0000_0000;
    wire        cp_acc   = cp_ir == jdta_pkg::IR_ACCESS;
    wire [5:0]  cp_len   = cp_acc ? jdta_pkg::LEN_WORD : jdta_pkg::LEN_BYPASS;
    wire [31:0] cp_cap   = cp_acc ? {acc_blk_q, 15'h0000, rdata_q} : 32'h0000_0000;
    wire [1:0]  new_tgt  = cp_dr[jdta_pkg::ACC_TGT_LSB +: 2];
    wire        blocked  = tap_off || (otp_off && new_tgt == jdta_pkg::TGT_OTP);
    wire        acc_go   = cp_upd && cp_acc;

    // boundary-scan tap first in chain, defaults to identification
    jdta_tap #(.IR_RESET(jdta_pkg::IR_DEVICE_IDENTIFICATION)) u_bs_tap (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .tap_rst  (tap_rst),
        .tck_rise (tck_rise),
        .tck_fall (tck_fall),
        .tms      (tms_s_q[1]),
        .tdi      (tdi_s_q[1]),
        .dr_len   (bs_len),
        .dr_cap   (bs_cap),
        .ir       (bs_ir),
        .dr       (bs_dr),
        .upd_dr   (bs_upd),
        .in_reset (bs_tlr),
        .shifting (),
        .tdo      (bs_tdo)
    );

    // chip tap second in chain, reaches tile, switch and otp
    jdta_tap #(.IR_RESET(jdta_pkg::IR_BYPASS)) u_chip_tap (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .tap_rst  (tap_rst),
        .tck_rise (tck_rise),
        .tck_fall (tck_fall),
        .tms      (tms_s_q[1]),
        .tdi      (bs_tdo),
        .dr_len   (cp_len),
        .dr_cap   (cp_cap),
        .ir       (cp_ir),
        .dr       (cp_dr),
        .upd_dr   (cp_upd),
        .in_reset (cp_tlr),
        .shifting (cp_shift),
        .tdo      (cp_tdo)
    );

    // serial out and its enable during shift states
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_q    <= cp_tdo;
            tdo_oe_q <= cp_shift && !tap_rst;
        end
    end

    // boundary update latch and pin drive under extest
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            bsr_upd_q <= 8'h00;
            pin_out_q <= 8'h00;
        end else begin
            if (bs_upd && bs_bsr) bsr_upd_q <= bs_dr[15:8];
            pin_out_q <= (bs_ir == jdta_pkg::IR_EXTEST) ? bsr_upd_q : core_out;
        end
    end

    // access request issued on chip tap data update
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            acc_req_q <= 1'b0;
            acc_wr_q  <= 1'b0;
            acc_tgt_q <= jdta_pkg::TGT_TILE;
            acc_adr_q <= 13'h0000;
            acc_wd_q  <= 16'h0000;
            acc_blk_q <= 1'b0;
            rd_pend_q <= 1'b0;
            rdata_q   <= 16'h0000;
        end else begin
            acc_req_q <= acc_go && !blocked;
            rd_pend_q <= acc_req_q && !acc_wr_q;
            if (acc_go) begin
                acc_wr_q  <= cp_dr[jdta_pkg::ACC_WR_BIT];
                acc_tgt_q <= new_tgt;
                acc_adr_q <= cp_dr[jdta_pkg::ACC_ADR_LSB +: 13];
                acc_wd_q  <= cp_dr[15:0];
                acc_blk_q <= blocked;
            end
            if (acc_go && blocked) begin
                rdata_q <= 16'h0000;
            end else if (rd_pend_q) begin
                rdata_q <= acc_rdata;
            end
        end
    end

    // debug pin: drive low at breakpoint, sense low to force debug
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dbg_oe_q <= 1'b0;
            force_q  <= 1'b0;
        end else begin
            dbg_oe_q <= dbg_out_en && at_breakpoint && !dbg_off;
            force_q  <= dbg_in_en && !dbg_s_q[1] && !dbg_off;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            boot_q     <= 1'b0;
            boot_sel_q <= 2'h0;
        end else if (!boot_q && lock_s_q[1]) begin
            boot_q     <= 1'b1;
            boot_sel_q <= boot_mode;
        end
    end

    assign tdo           = tdo_q;
    assign tdo_oe        = tdo_oe_q;
    assign io_pin_out    = pin_out_q;
    assign dbg_pin_out   = 1'b0;
    assign dbg_pin_oe    = dbg_oe_q;
    assign force_debug   = force_q;
    assign boot_start    = boot_q;
    assign boot_mode_sel = boot_sel_q;
    assign acc_req       = acc_req_q;
    assign acc_wr        = acc_wr_q;
    assign acc_target    = acc_tgt_q;
    assign acc_addr      = acc_adr_q;
    assign acc_wdata     = acc_wd_q;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    a_trst_hold_reset: assert property (tap_rst |=> bs_tlr && cp_tlr && !tdo_oe)
        else $error("test reset did not hold taps in reset");
    a_chain_default_ir: assert property (bs_tlr && cp_tlr |=> bs_ir == jdta_pkg::IR_DEVICE_IDENTIFICATION && cp_ir == jdta_pkg::IR_BYPASS)
        else $error("taps not in default instructions after reset");
    a_dbg_drive_low: assert property (dbg_out_en && at_breakpoint && !dbg_off |=> dbg_pin_oe && !dbg_pin_out)
        else $error("debug pin not driven low at breakpoint");
    a_dbg_float_idle: assert property (!at_breakpoint |=> !dbg_pin_oe)
        else $error("debug pin driven before breakpoint");
    a_dbg_force_in: assert property ((dbg_in_en && !dbg_off && !dbg_pin_in) [*4] |-> force_debug)
        else $error("low debug pin did not force debug");
    a_dbg_sync_lag: assert property ($fell(dbg_pin_in) && dbg_in_en && !force_debug |=> !force_debug)
        else $error("debug pin acted on without synchronisation");
    a_dbg_disabled: assert property (dbg_off |=> !dbg_pin_oe && !force_debug)
        else $error("debug pin active while disabled");
    a_otp_access_block: assert property (acc_req |-> !($past(otp_off) && acc_target == jdta_pkg::TGT_OTP))
        else $error("otp access issued while barred");
    a_tap_access_off: assert property ($past(tap_off) |-> !acc_req)
        else $error("access issued with test access disabled");
    a_boot_after_lock: assert property ($rose(boot_start) |-> $past(lock_s_q[1]) && boot_mode_sel == $past(boot_mode))
        else $error("boot started without pll lock");

    c_boot_start: cover property ($rose(boot_start));
    c_access_req: cover property (acc_req && acc_wr);
    c_force_debug: cover property ($rose(force_debug));
    c_dbg_drive: cover property ($rose(dbg_pin_oe));

endmodule

// >>> sim/jdta_host.sv
`timescale 1ns/100ps
module jdta_host (
    input  wire logic sys_clk,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    // test clock low and still between frames
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // one 80 ns test clock, tdo taken just before the rise
    task automatic step(input logic m, input logic d, output logic q);
        @(negedge sys_clk);
        tms = m;
        tdi = d;
        repeat (4) @(negedge sys_clk);
        q = tdo;
        tck = 1'b1;
        repeat (5) @(negedge sys_clk);
        tck = 1'b0;
    endtask

    // state move; data line toggles so a stale level is never trusted
    task automatic mv(input logic m);
        logic q;
        step(m, ~tdi, q);
    endtask

    // five ones reach test-logic-reset from anywhere, then idle
    task automatic walk_reset();
        repeat (5) mv(1'b1);
        mv(1'b0);
    endtask

    // from idle: optional 8-bit instruction load, then n-bit data scan, back to idle
    task automatic scan(input logic do_ir, input logic [7:0] ir, input int n,
                        input logic [63:0] din, output logic [63:0] dout);
        logic q;
        int   i;
        dout = 64'h0;
        if (do_ir) begin
            mv(1'b1);
            mv(1'b1);
            mv(1'b0);
            mv(1'b0);
            for (i = 0; i < 8; i++) step(i == 7, ir[i], q);
            mv(1'b1);
            mv(1'b0);
        end
        mv(1'b1);
        mv(1'b0);
        mv(1'b0);
        for (i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        mv(1'b1);
        mv(1'b0);
    endtask
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic        sys_clk, nrst, trst_n, tck, tms, tdi, tdo, tdo_oe;
    logic        pll_locked, boot_start, ext_low, acc_req, acc_wr;
    logic        dbg_out_en, dbg_in_en, at_breakpoint, dbg_pin_out, dbg_pin_oe, force_debug;
    logic [31:0] sec_bits, last;
    logic [1:0]  boot_mode, boot_mode_sel, acc_target;
    logic [7:0]  io_pin_in, core_out, io_pin_out;
    logic [12:0] acc_addr;
    logic [15:0] acc_wdata, acc_rdata;
    wire logic   dbg_pin_in;
    int          bad_count, num_checks, req_n, cyc, oe_n;
    localparam logic [31:0] ID_W = {jdta_pkg::ID_VERSION, jdta_pkg::ID_PART, jdta_pkg::ID_MAKER, 1'b1};

    jdta_host u_jdta_host (.sys_clk(sys_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    jdta_top u_jdta_top (
        .sys_clk(sys_clk), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
        .tdo(tdo), .tdo_oe(tdo_oe), .sec_bits(sec_bits), .pll_locked(pll_locked),
        .boot_mode(boot_mode), .boot_start(boot_start), .boot_mode_sel(boot_mode_sel),
        .io_pin_in(io_pin_in), .core_out(core_out), .io_pin_out(io_pin_out),
        .dbg_out_en(dbg_out_en), .dbg_in_en(dbg_in_en), .at_breakpoint(at_breakpoint),
        .dbg_pin_in(dbg_pin_in), .dbg_pin_out(dbg_pin_out), .dbg_pin_oe(dbg_pin_oe),
        .force_debug(force_debug), .acc_req(acc_req), .acc_wr(acc_wr), .acc_target(acc_target),
        .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata)
    );

    // open-drain debug line with board pull-up
    assign dbg_pin_in = ~((dbg_pin_oe & ~dbg_pin_out) | ext_low);

    // system clock, 8 ns
    always #4 sys_clk = ~sys_clk;

    // target answers a read from the address, ready the cycle after the request
    always @(negedge sys_clk) acc_rdata = {3'h0, acc_addr} ^ 16'h5a5a;

    // record every access request and its fields
    always @(posedge sys_clk) begin
        if (acc_req === 1'b1) begin
            req_n <= req_n + 1;
            last  <= {acc_wr, acc_target, acc_addr, acc_wdata};
        end
        // count cycles with the serial output enabled
        if (tdo_oe === 1'b1) oe_n <= oe_n + 1;
    end

    // hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            bad_count++;
            print_verdict();
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        chk({63'h0, got}, {63'h0, exp}, what);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // one access scan through the chip tap
    task automatic acc(input logic [31:0] sec, input logic [31:0] w, input logic go,
                       input logic ck, input logic [32:0] cap);
        logic [63:0] o;
        int          n0;
        @(negedge sys_clk);
        sec_bits = sec;
        n0 = req_n;
        u_jdta_host.scan(1'b1, {jdta_pkg::IR_BYPASS, jdta_pkg::IR_ACCESS}, 33, {32'h0, w}, o);
        repeat (8) @(negedge sys_clk);
        if (ck) chk(o[32:0], cap, "access capture");
        chk(64'(req_n - n0), {63'h0, go}, "request count");
        if (go) chk(last[31:16], w[31:16], "access fields");
        if (go && w[31]) chk(last[15:0], w[15:0], "write data");
    endtask

    initial begin
        logic [63:0] o;
        int          k;
        {sys_clk, nrst, trst_n, pll_locked, ext_low} = 5'h0;
        {dbg_out_en, dbg_in_en, at_breakpoint} = 3'h0;
        bad_count = 0;
        num_checks = 0;
        req_n = 0;
        cyc = 0;
        oe_n = 0;
        sec_bits = 32'h0;
        boot_mode = 2'h2;
        io_pin_in = 8'h96;
        core_out = 8'h3c;
        repeat (6) @(negedge sys_clk);
        nrst = 1'b1;
        // test reset kept low well past 100 ns after power-up
        repeat (16) @(negedge sys_clk);
        trst_n = 1'b1;
        repeat (6) @(negedge sys_clk);
        chk_bit(boot_start, 1'b0, "boot before lock");
        pll_locked = 1'b1;
        @(negedge sys_clk);
        chk_bit(boot_start, 1'b0, "boot too early");
        repeat (3) @(negedge sys_clk);
        chk_bit(boot_start, 1'b1, "boot after lock");
        chk(boot_mode_sel, 2'h2, "boot mode");
        // first data scan after reset: chip bypass bit then identification word
        chk(io_pin_out, core_out, "pins follow core");
        u_jdta_host.walk_reset();
        k = oe_n;
        u_jdta_host.scan(1'b0, 8'h0, 33, 64'h0, o);
        chk(64'(oe_n - k), 64'h14a, "tdo enable span");
        chk(o[32:0], {ID_W, 1'b0}, "id after reset");
        u_jdta_host.scan(1'b1, {jdta_pkg::IR_SAMPLE, jdta_pkg::IR_BYPASS}, 17, 64'h0, o);
        chk(o[16:0], {core_out, io_pin_in, 1'b0}, "boundary sample");
        // extest drives the update cells onto the pins
        u_jdta_host.scan(1'b1, {jdta_pkg::IR_EXTEST, jdta_pkg::IR_BYPASS}, 17, {47'h0, 8'hc3, 8'h00, 1'b0}, o);
        chk(o[16:0], {core_out, io_pin_in, 1'b0}, "extest capture");
        chk(io_pin_out, 8'hc3, "extest pins");
        for (k = 0; k < 2; k++) begin
            sec_bits = k[0] ? 32'ha940_0000 : 32'h0;
            u_jdta_host.scan(1'b1, {jdta_pkg::IR_USERCODE, jdta_pkg::IR_BYPASS}, 33, 64'h0, o);
            chk(o[32:0], {sec_bits[31:22], 6'h0, jdta_pkg::DIE_REVISION, 1'b0}, "usercode");
        end
        chk(io_pin_out, core_out, "pins back to core");
        acc(32'h0, {1'b1, jdta_pkg::TGT_TILE, 13'h0a5, 16'hbeef}, 1'b1, 1'b0, 33'h0);
        acc(32'h0, {1'b0, jdta_pkg::TGT_SWITCH, 13'h1b7, 16'h0}, 1'b1, 1'b0, 33'h0);
        acc(32'h2000, {1'b0, jdta_pkg::TGT_OTP, 13'h011, 16'h0}, 1'b0, 1'b1, {17'h0, 16'h5a5a ^ 16'h01b7});
        acc(32'h1, {1'b0, jdta_pkg::TGT_TILE, 13'h022, 16'h0}, 1'b0, 1'b1, 33'h080000000);
        acc(32'h0, {1'b1, jdta_pkg::TGT_OTP, 13'h033, 16'h1234}, 1'b1, 1'b1, 33'h080000000);
        // test reset alone brings the instruction back to identification
        trst_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        trst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        u_jdta_host.mv(1'b0);
        u_jdta_host.scan(1'b0, 8'h0, 33, 64'h0, o);
        chk(o[32:0], {ID_W, 1'b0}, "id after test reset");
        // every mix of output enable, breakpoint, input enable, board low and pin lock
        for (k = 0; k < 32; k++) begin
            @(negedge sys_clk);
            {dbg_out_en, at_breakpoint, dbg_in_en, ext_low} = k[3:0];
            sec_bits = {17'h0, k[4], 14'h0};
            repeat (6) @(negedge sys_clk);
            chk_bit(dbg_pin_oe, k[3] & k[2] & ~k[4], "pin drive");
            chk_bit(force_debug, k[1] & (k[0] | (k[3] & k[2])) & ~k[4], "force debug");
        end
        // global reset between clock edges acts at once
        nrst = 1'b0;
        #1 chk_bit(boot_start, 1'b0, "async reset");
        print_verdict();
    end
endmodule
